// >>> hw/ssf_pkg.sv
package ssf_pkg;
  // Register byte offsets
  localparam logic [7:0] SSF_OFS_STATUS  = 8'h00;
  localparam logic [7:0] SSF_OFS_DATA    = 8'h04;
  localparam logic [7:0] SSF_OFS_CONTROL = 8'h08;
  // Status field positions
  localparam int SSF_ST_TXE  = 7;
  localparam int SSF_ST_TXC  = 6;
  localparam int SSF_ST_RXF  = 5;
  localparam int SSF_ST_IDLE = 4;
  localparam int SSF_ST_OVR  = 3;
  localparam int SSF_ST_NSE  = 2;
  localparam int SSF_ST_FRM  = 1;
  // Control field positions
  localparam int SSF_CT_TXEM = 7;
  localparam int SSF_CT_TXCM = 6;
  localparam int SSF_CT_RXM  = 5;
  localparam int SSF_CT_ILM  = 4;
  localparam int SSF_CT_TEN  = 3;
  // Reset values
  localparam logic [7:0] SSF_CONTROL_RST = 8'h00;
  // Bit-rate ticks in one character time
  localparam int SSF_CHAR_BITS = 10;
  // Transmitter pin ownership states
  typedef enum logic [1:0] {SSF_TX_OFF, SSF_TX_RUN, SSF_TX_DRAIN} ssf_tx_state_t;
endpackage

// >>> hw/ssf_status_flags.sv
`timescale 1ns/1ps
// What this block does
// RQ1 - Flags are set by hardware events only and stay set until software clears.
// RQ2 - Flags clear as side effect of status read then data access.
// RQ3 - Enabling the transmitter sets transmit-empty and transmit-complete.
// RQ4 - Transmit-empty is set whenever the data register can take a character.
// RQ5 - Transmit-empty with its mask set requests an interrupt.
// RQ6 - Transmit-complete set when queue is drained and no character is in progress.
// RQ7 - Transmit-complete with its mask set requests an interrupt.
// RQ8 - Clearing enable mid-character lets that character finish.
// RQ9 - Only reset aborts the transmitter at once.
// RQ10 - Enable cleared while idle releases the pin on a bit-rate tick.
// RQ11 - Enable cleared mid-character drops queued data and releases the pin in the same cycle, when that character ends.
// RQ12 - That last character sets transmit-complete and transmit-empty.
// RQ13 - Five receive flags readable; full, overrun and idle can interrupt.
// RQ14 - Receive-full set when a character moves into the receive data register.
// RQ15 - Overrun keeps old character, drops new one, sets overrun not full.
// RQ16 - Noise and framing describe the held character and never interrupt.
// RQ17 - Line is idle after one full character time at logic one.
// RQ18 - Idle flag set only on a busy-to-idle change.
// RQ19 - All enabled flag sources combine into one interrupt request.
// RQ20 - Software reads status with the flag set, then accesses data.
module ssf_status_flags
  import ssf_pkg::*;
#(
  parameter int CHAR_BITS = SSF_CHAR_BITS
)(
  input  wire logic        hclk,          // Bus clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write direction
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic        hready,        // Bus ready in
  input  wire logic [31:0] hwdata,        // Write data
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response, always OKAY
  input  wire logic        bit_tick,      // Bit-rate clock tick
  input  wire logic        tx_busy,       // Shifter sending a character
  input  wire logic        tx_done,       // Shifter finished a character
  output logic             tx_start,      // Load shifter, one cycle
  output logic      [7:0]  tx_data,       // Character for the shifter
  output logic             tx_pin_owned,  // Transmit pin in serial use
  input  wire logic        rxd,           // Receive line level
  input  wire logic        rx_valid,      // Shifter has a character
  input  wire logic [7:0]  rx_data,       // Received character
  input  wire logic        rx_noise,      // Noise seen in that character
  input  wire logic        rx_framing,    // Bad stop bit in that character
  output logic             irq            // Interrupt request
);

  //--------------------------------------------------------------
  // Bus slave
  //--------------------------------------------------------------
  logic          acc_req;
  logic          rd_req;
  logic          wr_ff;
  logic [7:0]    wadr_ff;
  logic [31:0]   hrdata_ff;
  logic [31:0]   nxt_rdata;
  logic [7:0]    control_ff;
  logic [7:0]    status;
  logic          st_read;
  logic          data_read;
  logic          data_write;
  logic          ctl_write;

  assign acc_req    = hsel & htrans[1] & hready;
  assign rd_req     = acc_req & ~hwrite;
  assign st_read    = rd_req & (haddr[7:0] == SSF_OFS_STATUS);
  assign data_read  = rd_req & (haddr[7:0] == SSF_OFS_DATA);
  assign data_write = wr_ff & (wadr_ff == SSF_OFS_DATA);
  assign ctl_write  = wr_ff & (wadr_ff == SSF_OFS_CONTROL);
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_ff;

  // Write address phase captured for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ff   <= 1'b0;
      wadr_ff <= 8'h00;
    end
    else
    begin
      wr_ff   <= acc_req & hwrite & (haddr[31:8] == 24'h000000);
      wadr_ff <= haddr[7:0];
    end
  end

  // Read mux, unmapped reads as zero
  logic [7:0] rdr_ff;
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (haddr[31:8] == 24'h000000)
    begin
      unique case (haddr[7:0])
        SSF_OFS_STATUS:  nxt_rdata = {24'h000000, status};
        SSF_OFS_DATA:    nxt_rdata = {24'h000000, rdr_ff};
        SSF_OFS_CONTROL: nxt_rdata = {24'h000000, control_ff};
        default:         nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0000_0000;
    else if (rd_req)
      hrdata_ff <= nxt_rdata;
  end

  // Control register: masks and transmitter enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      control_ff <= SSF_CONTROL_RST;
    else if (ctl_write)
      control_ff <= hwdata[7:0];
  end

  //--------------------------------------------------------------
  // Clearing interlock
  //--------------------------------------------------------------
  logic [7:0] arm_ff;
  logic [7:0] clr;

  // Status read arms each flag seen set; data access fires it, except noise and framing, which change only when the next character loads
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      arm_ff <= 8'h00;
    else if (st_read)
      arm_ff <= status;                                        // RQ2
    else if (data_read | data_write)
      arm_ff <= 8'h00;
  end

  // Transmit flags clear on data write; receive-full, idle and overrun on data read
  always_comb
  begin
    clr = 8'h00;
    clr[SSF_ST_TXE]  = data_write & arm_ff[SSF_ST_TXE];        // RQ2
    clr[SSF_ST_TXC]  = data_write & arm_ff[SSF_ST_TXC];
    clr[SSF_ST_RXF]  = data_read & arm_ff[SSF_ST_RXF];
    clr[SSF_ST_IDLE] = data_read & arm_ff[SSF_ST_IDLE];
    clr[SSF_ST_OVR]  = data_read & arm_ff[SSF_ST_OVR];
  end

  //--------------------------------------------------------------
  // Transmitter
  //--------------------------------------------------------------
  ssf_tx_state_t tx_state_ff;
  logic          ten;
  logic          tdr_full_ff;
  logic [7:0]    tdr_ff;
  logic          tx_start_ff;
  logic [7:0]    tx_data_ff;
  logic          txe_ff;
  logic          txc_ff;
  logic          tx_enter;
  logic          tx_load;
  logic          drain_end;

  assign ten       = control_ff[SSF_CT_TEN];
  assign tx_enter  = (tx_state_ff == SSF_TX_OFF) & ten;
  assign tx_load   = (tx_state_ff == SSF_TX_RUN) & ten & tdr_full_ff
                     & ~tx_busy & ~tx_start_ff;
  assign drain_end = (tx_state_ff == SSF_TX_DRAIN) & tx_done;
  assign tx_start     = tx_start_ff;
  assign tx_data      = tx_data_ff;
  assign tx_pin_owned = (tx_state_ff != SSF_TX_OFF);

  // Pin ownership and graceful shutdown
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_state_ff <= SSF_TX_OFF;                               // RQ9
    else
    begin
      unique case (tx_state_ff)
        SSF_TX_OFF:
          if (ten)
            tx_state_ff <= SSF_TX_RUN;
        SSF_TX_RUN:
          if (!ten && (tx_busy || tx_start_ff))
            tx_state_ff <= SSF_TX_DRAIN;                       // RQ8
          else if (!ten && bit_tick)
            tx_state_ff <= SSF_TX_OFF;                         // RQ10
        SSF_TX_DRAIN:
          if (tx_done)
            tx_state_ff <= SSF_TX_OFF;                         // RQ11
      endcase
    end
  end

  // Transmit data register, one-character queue
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tdr_full_ff <= 1'b0;
      tdr_ff      <= 8'h00;
    end
    else if (drain_end)
      tdr_full_ff <= 1'b0;                                     // RQ11
    else if (data_write)
    begin
      tdr_full_ff <= 1'b1;
      tdr_ff      <= hwdata[7:0];
    end
    else if (tx_load)
      tdr_full_ff <= 1'b0;
  end

  // Hand-off to the shifter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_start_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end
    else
    begin
      tx_start_ff <= tx_load;
      if (tx_load)
        tx_data_ff <= tdr_ff;
    end
  end

  // Transmit-empty flag, set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      txe_ff <= 1'b0;
    else if (tx_enter || tx_load || drain_end)
      txe_ff <= 1'b1;                                          // RQ3 RQ4 RQ12
    else if (clr[SSF_ST_TXE])
      txe_ff <= 1'b0;                                          // RQ1
  end

  // Transmit-complete flag, set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      txc_ff <= 1'b0;
    else if (tx_enter || drain_end
             || (tx_done && !tdr_full_ff && !tx_start_ff))
      txc_ff <= 1'b1;                                          // RQ3 RQ6 RQ12
    else if (clr[SSF_ST_TXC])
      txc_ff <= 1'b0;                                          // RQ1
  end

  //--------------------------------------------------------------
  // Receiver
  //--------------------------------------------------------------
  logic       rxf_ff;
  logic       ovr_ff;
  logic       nse_ff;
  logic       frm_ff;
  logic       idle_ff;
  logic       line_busy_ff;
  logic [7:0] idle_cnt_ff;
  logic       idle_hit;

  // Receive data register with overrun protection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdr_ff <= 8'h00;
      nse_ff <= 1'b0;
      frm_ff <= 1'b0;
    end
    else if (rx_valid && !rxf_ff)
    begin
      rdr_ff <= rx_data;                                       // RQ15
      nse_ff <= rx_noise;                                      // RQ16
      frm_ff <= rx_framing;
    end
  end

  // Receive-full and overrun flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxf_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end
    else
    begin
      if (rx_valid && !rxf_ff)
        rxf_ff <= 1'b1;                                        // RQ14
      else if (clr[SSF_ST_RXF])
        rxf_ff <= 1'b0;
      if (rx_valid && rxf_ff)
        ovr_ff <= 1'b1;                                        // RQ15
      else if (clr[SSF_ST_OVR])
        ovr_ff <= 1'b0;
    end
  end

  assign idle_hit = bit_tick & rxd & line_busy_ff
                    & (idle_cnt_ff == 8'(CHAR_BITS - 1));

  // Character-time count of ones on the receive line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idle_cnt_ff  <= 8'h00;
      line_busy_ff <= 1'b0;
    end
    else if (!rxd)
    begin
      idle_cnt_ff  <= 8'h00;
      line_busy_ff <= 1'b1;                                    // RQ18
    end
    else if (idle_hit)
    begin
      idle_cnt_ff  <= 8'h00;
      line_busy_ff <= 1'b0;                                    // RQ18
    end
    else if (bit_tick && line_busy_ff)
      idle_cnt_ff <= idle_cnt_ff + 8'h01;                      // RQ17
  end

  // Line-idle flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idle_ff <= 1'b0;
    else if (idle_hit)
      idle_ff <= 1'b1;                                         // RQ17
    else if (clr[SSF_ST_IDLE])
      idle_ff <= 1'b0;
  end

  //--------------------------------------------------------------
  // Status and interrupt
  //--------------------------------------------------------------
  logic nxt_irq;
  logic irq_ff;

  // Status byte visible to software at any time
  always_comb
  begin
    status = 8'h00;
    status[SSF_ST_TXE]  = txe_ff;                              // RQ13
    status[SSF_ST_TXC]  = txc_ff;
    status[SSF_ST_RXF]  = rxf_ff;
    status[SSF_ST_IDLE] = idle_ff;
    status[SSF_ST_OVR]  = ovr_ff;
    status[SSF_ST_NSE]  = nse_ff;
    status[SSF_ST_FRM]  = frm_ff;
  end

  // Noise and framing are deliberately absent from the request
  assign nxt_irq = (txe_ff & control_ff[SSF_CT_TXEM])          // RQ5
                 | (txc_ff & control_ff[SSF_CT_TXCM])          // RQ7
                 | ((rxf_ff | ovr_ff) & control_ff[SSF_CT_RXM])
                 | (idle_ff & control_ff[SSF_CT_ILM]);         // RQ19

  // Registered request output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= nxt_irq;
  end
  assign irq = irq_ff;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TXE_IRQ: assert property (txe_ff && control_ff[SSF_CT_TXEM] |=> irq) // RQ5
    else $error("transmit-empty request missing");
  AST_TXC_IRQ: assert property (txc_ff && control_ff[SSF_CT_TXCM] |=> irq) // RQ7
    else $error("transmit-complete request missing");
  AST_NO_IRQ: assert property (!nxt_irq |=> !irq) // RQ19
    else $error("request without enabled source");
  AST_ENABLE_FLAGS: assert property (tx_enter |=> txe_ff && txc_ff) // RQ3
    else $error("enable did not set transmit flags");
  AST_DRAIN_END: assert property (drain_end |=> txe_ff && txc_ff && !tx_pin_owned
                                  && !tdr_full_ff) // RQ12
    else $error("last character did not finish cleanly");
  AST_NO_ABORT: assert property (tx_state_ff == SSF_TX_DRAIN && !tx_done
                                 |=> tx_pin_owned) // RQ8
    else $error("pin released before character end");
  AST_IDLE_RELEASE: assert property (tx_pin_owned && !ten && !tx_busy && !tx_start_ff
                                     && !bit_tick && tx_state_ff == SSF_TX_RUN
                                     |=> tx_pin_owned) // RQ10
    else $error("pin released off the bit tick");
  AST_OVERRUN_KEEP: assert property (rx_valid && rxf_ff
                                     |=> ovr_ff && $stable(rdr_ff)) // RQ15
    else $error("overrun disturbed held character");
  AST_RX_LOAD: assert property (rx_valid && !rxf_ff |=> rxf_ff && rdr_ff == $past(rx_data)) // RQ14
    else $error("receive register not loaded");
  AST_IDLE_ONCE: assert property (idle_hit |=> !line_busy_ff) // RQ18
    else $error("idle detector rearmed without activity");
  AST_FLAG_HOLD: assert property (rxf_ff && !data_read |=> rxf_ff) // RQ1
    else $error("receive-full cleared without servicing");

endmodule

// >>> sim/ssf_far_side.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Far side: bit-rate clock, transmit and receive shifters
// ---------------------------------------------
module ssf_far_side #(
  parameter int TICK_DIV = 4,  // Bus cycles per bit tick
  parameter int TX_TICKS = 10  // Bit ticks per sent character
)(
  input  wire logic       hclk,       // Bus clock
  input  wire logic       hresetn,    // Reset, active low
  input  wire logic       tx_start,   // Load request from the block
  input  wire logic [7:0] tx_data,    // Character to send
  output logic            bit_tick,   // Bit-rate pulse
  output logic            tx_busy,    // Sending a character
  output logic            tx_done,    // Character finished
  output logic            rxd,        // Receive line
  output logic            rx_valid,   // Character ready
  output logic [7:0]      rx_data,    // Received character
  output logic            rx_noise,   // Noise seen
  output logic            rx_framing  // Bad stop bit
);
  int div_cnt;
  int tick_cnt;
  // Line idles high; qualified data shows garbage outside its pulse
  initial
  begin
    rxd        = 1'b1;
    rx_valid   = 1'b0;
    rx_data    = 8'hFF;
    rx_noise   = 1'b1;
    rx_framing = 1'b1;
  end
  // Tick generator
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      div_cnt  <= 0;
      bit_tick <= 1'b0;
    end
    else
    begin
      div_cnt  <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      bit_tick <= (div_cnt == TICK_DIV - 1);
    end
  // Shifter goes busy the cycle after a load; done pulses for one cycle as busy falls
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_busy  <= 1'b0;
      tx_done  <= 1'b0;
      tick_cnt <= 0;
    end
    else
    begin
      tx_done <= 1'b0;
      if (tx_start)
      begin
        tx_busy  <= 1'b1;
        tick_cnt <= 0;
      end
      else if (tx_busy && bit_tick)
      begin
        tx_busy  <= (tick_cnt != TX_TICKS - 1);
        tx_done  <= (tick_cnt == TX_TICKS - 1);
        tick_cnt <= tick_cnt + 1;
      end
    end
  // Frame on the line, LSB first, then one-cycle character pulse
  task send_rx(input logic [7:0] d, input logic nz, input logic fr);
    int i;
    for (i = 0; i < 10; i++)
    begin
      @(posedge hclk iff bit_tick === 1'b1);
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
    end
    @(posedge hclk);
    rx_valid   <= 1'b1;
    rx_data    <= d;
    rx_noise   <= nz;
    rx_framing <= fr;
    @(posedge hclk);
    rx_valid   <= 1'b0;
    rx_data    <= ~d;
    rx_noise   <= ~nz;
    rx_framing <= ~fr;
  endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb
  import ssf_pkg::*;
;
  localparam logic [31:0] TXE = 32'h1 << SSF_ST_TXE;
  localparam logic [31:0] TXC = 32'h1 << SSF_ST_TXC;
  localparam logic [31:0] RXF = 32'h1 << SSF_ST_RXF;
  localparam logic [31:0] IDL = 32'h1 << SSF_ST_IDLE;
  localparam logic [31:0] OVR = 32'h1 << SSF_ST_OVR;
  localparam logic [31:0] NSE = 32'h1 << SSF_ST_NSE;
  localparam logic [31:0] FRM = 32'h1 << SSF_ST_FRM;
  localparam logic [31:0] TEN = 32'h1 << SSF_CT_TEN;
  typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] wd; logic [31:0] ex;} ssf_row_t;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, bit_tick;
  logic        tx_busy, tx_done, tx_start, pin, rxd, rx_valid, rx_noise, rx_framing, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  tx_data, rx_data;
  logic [31:0] haddr, hwdata, hrdata, rd, masks [2];
  ssf_row_t    rows [6];
  int          errors, n_tests, n_start, starts;
  assign hready = hreadyout;
  ssf_status_flags #(.CHAR_BITS(3)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bit_tick(bit_tick), .tx_busy(tx_busy), .tx_done(tx_done), .tx_start(tx_start),
    .tx_data(tx_data), .tx_pin_owned(pin), .rxd(rxd), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_noise(rx_noise), .rx_framing(rx_framing), .irq(irq));
  ssf_far_side #(.TICK_DIV(4), .TX_TICKS(10)) far (.hclk(hclk), .hresetn(hresetn),
    .tx_start(tx_start), .tx_data(tx_data), .bit_tick(bit_tick), .tx_busy(tx_busy),
    .tx_done(tx_done), .rxd(rxd), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_noise(rx_noise), .rx_framing(rx_framing));
  // Clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Count shifter loads
  always @(posedge hclk)
    if (tx_start === 1'b1) n_start <= n_start + 1;
  task chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
    end
  endtask
  // One AHB-Lite single word transfer
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    // Only the watchdog ends a wait for ready
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task st(input string what, input logic [31:0] ex);
    bus(1'b0, SSF_OFS_STATUS, 32'h0, rd);
    chk(what, ex, rd);
  endtask
  // Bounded wait for a start (0) or done (1) pulse
  task wait_for(input int which);
    int k;
    for (k = 0; k < 500; k++)
    begin
      @(posedge hclk);
      if ((which == 0 ? tx_start : tx_done) === 1'b1) break;
    end
    if (k == 500) chk("shifter pulse", 32'h1, 32'h0);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (40000) @(posedge hclk);
    errors++;
    $display("watchdog expired");
    wrap_up;
  end
  // Main sequence
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    haddr = 32'h0; hwdata = 32'h0; errors = 0; n_tests = 0; n_start = 0;
    rows[0] = '{1'b0, SSF_OFS_STATUS, 32'h0, 32'h0};
    rows[1] = '{1'b0, SSF_OFS_CONTROL, 32'h0, 32'h0};
    rows[2] = '{1'b0, 8'h0C, 32'h0, 32'h0};
    rows[3] = '{1'b1, SSF_OFS_CONTROL, TEN, 32'h0};
    rows[4] = '{1'b0, SSF_OFS_CONTROL, 32'h0, TEN};
    rows[5] = '{1'b0, SSF_OFS_STATUS, 32'h0, TXE | TXC};
    masks[0] = 32'h1 << SSF_CT_TXEM;
    masks[1] = 32'h1 << SSF_CT_TXCM;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      bus(rows[i].wr, rows[i].addr, rows[i].wd, rd);
      if (!rows[i].wr) chk("table read", rows[i].ex, rd);
    end
    $display("table done");
    foreach (masks[i])
    begin
      bus(1'b1, SSF_OFS_CONTROL, TEN | masks[i], rd);
      repeat (2) @(posedge hclk);
      chk("irq mask on", 32'h1, {31'h0, irq});
      bus(1'b1, SSF_OFS_CONTROL, TEN, rd);
      repeat (2) @(posedge hclk);
      chk("irq mask off", 32'h0, {31'h0, irq});
    end
    $display("mask test done");
    st("status arm", TXE | TXC);
    bus(1'b1, SSF_OFS_DATA, 32'h5A, rd);
    wait_for(0);
    chk("tx byte", 32'h5A, {24'h0, tx_data});
    st("status sending", TXE);
    wait_for(1);
    repeat (2) @(posedge hclk);
    st("status sent", TXE | TXC);
    $display("transmit test done");
    st("status arm", TXE | TXC);
    bus(1'b1, SSF_OFS_DATA, 32'h11, rd);
    wait_for(0);
    bus(1'b1, SSF_OFS_DATA, 32'h22, rd);
    // Sampled once the load count has settled; shifter is still busy here
    starts = n_start;
    bus(1'b1, SSF_OFS_CONTROL, 32'h0, rd);
    st("status draining", TXE);
    chk("pin while draining", 32'h1, {31'h0, pin});
    wait_for(1);
    repeat (4) @(posedge hclk);
    chk("pin after drain", 32'h0, {31'h0, pin});
    chk("loads after drain", starts, n_start);
    st("status drained", TXE | TXC);
    $display("drain test done");
    bus(1'b1, SSF_OFS_CONTROL, TEN, rd);
    repeat (2) @(posedge hclk);
    chk("pin enabled", 32'h1, {31'h0, pin});
    bus(1'b1, SSF_OFS_CONTROL, 32'h0, rd);
    @(posedge hclk iff bit_tick === 1'b1);
    repeat (3) @(posedge hclk);
    chk("pin idle release", 32'h0, {31'h0, pin});
    $display("idle release test done");
    bus(1'b1, SSF_OFS_CONTROL, 32'h1 << SSF_CT_RXM, rd);
    far.send_rx(8'hA5, 1'b1, 1'b0);
    repeat (20) @(posedge hclk);
    st("status received", TXE | TXC | RXF | IDL | NSE);
    chk("irq receive", 32'h1, {31'h0, irq});
    far.send_rx(8'h3C, 1'b0, 1'b1);
    repeat (20) @(posedge hclk);
    st("status overrun", TXE | TXC | RXF | IDL | OVR | NSE);
    bus(1'b0, SSF_OFS_DATA, 32'h0, rd);
    chk("kept character", 32'hA5, rd);
    repeat (20) @(posedge hclk);
    st("status serviced", TXE | TXC | NSE);
    chk("irq noise only", 32'h0, {31'h0, irq});
    bus(1'b1, SSF_OFS_CONTROL, 32'h1 << SSF_CT_ILM, rd);
    far.send_rx(8'h5A, 1'b0, 1'b1);
    repeat (20) @(posedge hclk);
    chk("irq idle", 32'h1, {31'h0, irq});
    st("status framing", TXE | TXC | RXF | IDL | FRM);
    $display("receive test done");
    bus(1'b1, SSF_OFS_CONTROL, TEN, rd);
    bus(1'b1, SSF_OFS_DATA, 32'h77, rd);
    wait_for(0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("pin in reset", 32'h0, {31'h0, pin});
    hresetn <= 1'b1;
    st("status after reset", 32'h0);
    $display("reset test done");
    wrap_up;
  end
endmodule
